// ### hw/lpm_pkg.sv
package lpm_pkg;

	// ============================================================
	// Register map (word offsets as byte addresses)
	localparam logic [7:0] ADDR_CORE_STATE   = 8'h00;
	localparam logic [7:0] ADDR_MODULE_EN    = 8'h04;
	localparam logic [7:0] ADDR_LOCAL_SAVE   = 8'h08;
	localparam logic [7:0] ADDR_FLL_FACTOR   = 8'h0C;
	localparam logic [7:0] ADDR_MODE_STATUS  = 8'h10;
	localparam logic [7:0] ADDR_PERIPH_BASE  = 8'h20;

	// ============================================================
	// Core state register bit positions
	localparam int BIT_CORE_HALT   = 4;
	localparam int BIT_OSC_DISABLE = 5;
	localparam int BIT_GATE_LO     = 6;
	localparam int BIT_GATE_HI     = 7;

	// ============================================================
	// Sizes and reset values
	localparam int NUM_PERIPH = 4;
	localparam int NEST_DEPTH = 8;
	localparam int PTR_W      = 4;
	localparam logic [6:0]  FLL_FACTOR_RESET = 7'h1F;
	localparam logic [3:0]  CTL_RESET        = 4'h0;
	localparam logic [NUM_PERIPH-1:0] MODULE_EN_RESET  = 4'h0;
	localparam logic [NUM_PERIPH-1:0] LOCAL_SAVE_RESET = 4'h0;
	localparam logic [9:0]  DCO_MIN_TAP      = 10'h000;
	localparam logic [9:0]  DCO_MAX_TAP      = 10'h3FF;

	// ============================================================
	// Operating modes
	typedef enum logic [2:0] {
		active_run_mode      = 3'b000,
		low_power_mode_zero  = 3'b001,
		low_power_mode_one   = 3'b011,
		low_power_mode_two   = 3'b010,
		low_power_mode_three = 3'b110,
		low_power_mode_four  = 3'b111
	} op_mode_t;

	// Four control bits of the core state register
	typedef struct packed {
		logic sys_clock_gate_hi;
		logic sys_clock_gate_lo;
		logic crystal_osc_disable;
		logic core_halt_bit;
	} ctl_bits_t;

	// Clock tree enables
	typedef struct packed {
		logic cpu_run;
		logic aux_clk_on;
		logic master_clk_on;
		logic fll_on;
		logic dc_gen_on;
	} clk_en_t;

endpackage

// ### hw/low_power_mode_clock_gating.sv
// The Wishbone register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Function
// - Any interrupt wakes to active; interrupt return restores the prior mode for up to eight nested levels.
// - Auxiliary clock runs at crystal rate; master clock is integer multiple of it.
// - Active mode runs CPU with any set of peripherals enabled.
// - Mode zero halts CPU; both clocks and loop control stay on.
// - Mode one halts CPU; both clocks on, loop control stopped.
// - Mode two halts CPU; only auxiliary clock on.
// - Mode three as mode two, plus oscillator dc generator off.
// - Mode four stops crystal, all clocks, loop and dc generator.
// - Each peripheral has an enable bit that starts or stops it.
// - Peripheral registers stay accessible whether module is stopped or enabled.
// - Each peripheral has one local bit switching its current-saving function.
// - Four core state bits control CPU and clock generator.
// - Oscillator-off bit clears at power-up; writing one stops the oscillator.
// - Loop makes system clock factor plus one times crystal; factor resets to 31.
// - Power-up clear sets oscillator to lowest tap; control starts right after.
module low_power_mode_clock_gating (
	// System
	input  wire logic                         clk,
	input  wire logic                         reset,
	// Wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [31:0]                  wb_dat_i,
	input  wire logic [3:0]                   wb_sel_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// Core events
	input  wire logic                         irq_event,
	input  wire logic                         interrupt_return_instr,
	// Oscillator ticks from the analog side
	input  wire logic                         crystal_tick_pin,
	input  wire logic                         dco_tick_pin,
	// Clock tree controls
	output lpm_pkg::clk_en_t                  clk_en,
	output logic      [lpm_pkg::NUM_PERIPH-1:0] periph_run,
	output logic      [lpm_pkg::NUM_PERIPH-1:0] periph_save,
	output logic      [9:0]                   dco_tap
);

	// ============================================================
	// Decoding
	function automatic lpm_pkg::op_mode_t decode_mode(input lpm_pkg::ctl_bits_t c);
		if (!c.core_halt_bit)
			decode_mode = lpm_pkg::active_run_mode;
		else if (c.crystal_osc_disable)
			decode_mode = lpm_pkg::low_power_mode_four;
		else if (c.sys_clock_gate_hi && c.sys_clock_gate_lo)
			decode_mode = lpm_pkg::low_power_mode_three;
		else if (c.sys_clock_gate_hi)
			decode_mode = lpm_pkg::low_power_mode_two;
		else if (c.sys_clock_gate_lo)
			decode_mode = lpm_pkg::low_power_mode_one;
		else
			decode_mode = lpm_pkg::low_power_mode_zero;
	endfunction

	function automatic lpm_pkg::clk_en_t mode_enables(input lpm_pkg::op_mode_t m);
		mode_enables = '{default: 1'b0};
		unique case (m)
			lpm_pkg::active_run_mode:      mode_enables = 5'b11111;
			lpm_pkg::low_power_mode_zero:  mode_enables = 5'b01111;
			lpm_pkg::low_power_mode_one:   mode_enables = 5'b01101;
			lpm_pkg::low_power_mode_two:   mode_enables = 5'b01001;
			lpm_pkg::low_power_mode_three: mode_enables = 5'b01000;
			lpm_pkg::low_power_mode_four:  mode_enables = 5'b00000;
			default:                       mode_enables = 5'b00000;
		endcase
	endfunction

	// ============================================================
	// State
	lpm_pkg::ctl_bits_t                ctl;
	lpm_pkg::ctl_bits_t                nest_stack [lpm_pkg::NEST_DEPTH];
	logic [lpm_pkg::PTR_W-1:0]         nest_ptr;
	logic [lpm_pkg::NUM_PERIPH-1:0]    module_en;
	logic [lpm_pkg::NUM_PERIPH-1:0]    local_save;
	logic [6:0]                        fll_factor;
	logic [7:0]                        periph_reg [lpm_pkg::NUM_PERIPH];
	logic [1:0]                        xtal_sync;
	logic [1:0]                        dco_sync;
	logic                              xtal_prev;
	logic                              dco_prev;
	logic [7:0]                        dco_count;
	lpm_pkg::op_mode_t                 mode;
	lpm_pkg::clk_en_t                  next_clk_en;
	logic                              wb_req;
	logic                              wb_wr;
	logic                              xtal_edge;
	logic                              dco_edge;

	assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr     = wb_req && wb_we_i && wb_sel_i[0];
	assign mode      = decode_mode(ctl);
	assign xtal_edge = xtal_sync[1] && !xtal_prev;
	assign dco_edge  = dco_sync[1] && !dco_prev;

	// ============================================================
	// Core state bits and interrupt nesting
	// Interrupt wins over a same-cycle write so no wake is lost
	always_ff @(posedge clk) begin
		if (reset) begin
			ctl      <= lpm_pkg::CTL_RESET;
			nest_ptr <= '0;
		end else if (irq_event) begin
			if (nest_ptr < 4'(lpm_pkg::NEST_DEPTH)) begin
				nest_stack[nest_ptr[2:0]] <= ctl;
				nest_ptr                  <= nest_ptr + 4'h1;
			end
			ctl <= lpm_pkg::CTL_RESET;
		end else if (interrupt_return_instr && nest_ptr != 4'h0) begin
			ctl      <= nest_stack[nest_ptr[2:0] - 3'h1];
			nest_ptr <= nest_ptr - 4'h1;
		end else if (wb_wr && wb_adr_i == lpm_pkg::ADDR_CORE_STATE) begin
			ctl.core_halt_bit       <= wb_dat_i[lpm_pkg::BIT_CORE_HALT];
			ctl.crystal_osc_disable <= wb_dat_i[lpm_pkg::BIT_OSC_DISABLE];
			ctl.sys_clock_gate_lo   <= wb_dat_i[lpm_pkg::BIT_GATE_LO];
			ctl.sys_clock_gate_hi   <= wb_dat_i[lpm_pkg::BIT_GATE_HI];
		end
	end

	// ============================================================
	// Enables and peripheral registers
	always_ff @(posedge clk) begin
		if (reset) begin
			module_en  <= lpm_pkg::MODULE_EN_RESET;
			local_save <= lpm_pkg::LOCAL_SAVE_RESET;
			fll_factor <= lpm_pkg::FLL_FACTOR_RESET;
		end else if (wb_wr) begin
			if (wb_adr_i == lpm_pkg::ADDR_MODULE_EN)
				module_en <= wb_dat_i[lpm_pkg::NUM_PERIPH-1:0];
			if (wb_adr_i == lpm_pkg::ADDR_LOCAL_SAVE)
				local_save <= wb_dat_i[lpm_pkg::NUM_PERIPH-1:0];
			if (wb_adr_i == lpm_pkg::ADDR_FLL_FACTOR)
				fll_factor <= wb_dat_i[6:0];
		end
	end

	// Peripheral registers ignore module_en: stopped modules stay reachable
	genvar gi;
	generate
		for (gi = 0; gi < lpm_pkg::NUM_PERIPH; gi++) begin : g_periph
			always_ff @(posedge clk) begin
				if (reset)
					periph_reg[gi] <= 8'h00;
				else if (wb_wr && wb_adr_i == lpm_pkg::ADDR_PERIPH_BASE + 8'(4 * gi))
					periph_reg[gi] <= wb_dat_i[7:0];
			end
		end
	endgenerate

	// ============================================================
	// Wishbone answer, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					lpm_pkg::ADDR_CORE_STATE:  wb_dat_o <= {24'h0, ctl, 4'h0};
					lpm_pkg::ADDR_MODULE_EN:   wb_dat_o <= {28'h0, module_en};
					lpm_pkg::ADDR_LOCAL_SAVE:  wb_dat_o <= {28'h0, local_save};
					lpm_pkg::ADDR_FLL_FACTOR:  wb_dat_o <= {25'h0, fll_factor};
					lpm_pkg::ADDR_MODE_STATUS: wb_dat_o <= {24'h0, nest_ptr, 1'b0, mode};
					8'h20:                     wb_dat_o <= {24'h0, periph_reg[0]};
					8'h24:                     wb_dat_o <= {24'h0, periph_reg[1]};
					8'h28:                     wb_dat_o <= {24'h0, periph_reg[2]};
					8'h2C:                     wb_dat_o <= {24'h0, periph_reg[3]};
					default:                   wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ============================================================
	// Clock tree outputs
	always_comb begin
		next_clk_en            = mode_enables(mode);
		// Crystal off stops the auxiliary clock even while the core runs
		next_clk_en.aux_clk_on = next_clk_en.aux_clk_on && !ctl.crystal_osc_disable;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			clk_en      <= 5'b11111;
			periph_run  <= lpm_pkg::MODULE_EN_RESET;
			periph_save <= lpm_pkg::LOCAL_SAVE_RESET;
		end else begin
			clk_en      <= next_clk_en;
			// Peripherals keep running in every mode; only their enable bit stops them
			periph_run  <= module_en;
			periph_save <= local_save;
		end
	end

	// ============================================================
	// Oscillator tick synchronisers
	always_ff @(posedge clk) begin
		if (reset) begin
			xtal_sync <= 2'h0;
			dco_sync  <= 2'h0;
			xtal_prev <= 1'b0;
			dco_prev  <= 1'b0;
		end else begin
			xtal_sync <= {xtal_sync[0], crystal_tick_pin};
			dco_sync  <= {dco_sync[0], dco_tick_pin};
			xtal_prev <= xtal_sync[1];
			dco_prev  <= dco_sync[1];
		end
	end

	// ============================================================
	// Frequency lock: count master ticks per crystal period, steer the tap
	// Target is factor plus one master ticks per crystal tick; one step per period
	always_ff @(posedge clk) begin
		if (reset) begin
			dco_count <= 8'h00;
			dco_tap   <= lpm_pkg::DCO_MIN_TAP;
		end else if (xtal_edge) begin
			dco_count <= 8'(dco_edge);
			if (clk_en.fll_on) begin
				if (dco_count < 8'(fll_factor) + 8'h01 && dco_tap != lpm_pkg::DCO_MAX_TAP)
					dco_tap <= dco_tap + 10'h001;
				else if (dco_count > 8'(fll_factor) + 8'h01 && dco_tap != lpm_pkg::DCO_MIN_TAP)
					dco_tap <= dco_tap - 10'h001;
			end
		end else if (dco_edge && dco_count != 8'hFF) begin
			dco_count <= dco_count + 8'h01;
		end
	end

	// ============================================================
	// Checks
	sequence s_irq_wake;
		irq_event ##1 1'b1;
	endsequence

	a_irq_wakes_core: assert property (@(posedge clk) disable iff (reset)
		s_irq_wake |-> mode == lpm_pkg::active_run_mode ##1 clk_en.cpu_run)
		else $error("interrupt did not wake core");

	a_interrupt_return_instr_restores_mode: assert property (@(posedge clk) disable iff (reset)
		irq_event && nest_ptr < 4'h8 ##1 !irq_event && interrupt_return_instr
		|=> ctl == $past(ctl, 2))
		else $error("return did not restore mode");

	a_mode_four_stops: assert property (@(posedge clk) disable iff (reset)
		mode == lpm_pkg::low_power_mode_four |=> clk_en == 5'b00000 && periph_run == $past(module_en))
		else $error("mode four left clocks on");

	a_mode_three_aux: assert property (@(posedge clk) disable iff (reset)
		mode == lpm_pkg::low_power_mode_three |=> clk_en.aux_clk_on && !clk_en.dc_gen_on)
		else $error("mode three enables wrong");

	a_mode_one_loop: assert property (@(posedge clk) disable iff (reset)
		mode == lpm_pkg::low_power_mode_one |=> clk_en.master_clk_on && !clk_en.fll_on)
		else $error("mode one loop not stopped");

	a_mode_zero_loop: assert property (@(posedge clk) disable iff (reset)
		mode == lpm_pkg::low_power_mode_zero |=> !clk_en.cpu_run && clk_en.fll_on)
		else $error("mode zero enables wrong");

	a_halt_decodes: assert property (@(posedge clk) disable iff (reset)
		ctl.core_halt_bit == (mode != lpm_pkg::active_run_mode))
		else $error("halt bit decode wrong");

	a_enable_follows: assert property (@(posedge clk) disable iff (reset)
		wb_wr && wb_adr_i == lpm_pkg::ADDR_MODULE_EN && !ctl.crystal_osc_disable
		##1 !ctl.crystal_osc_disable |=> periph_run == $past(wb_dat_i[3:0], 2))
		else $error("module enable not applied");

	a_factor_reset: assert property (@(posedge clk)
		$past(reset) |-> fll_factor == lpm_pkg::FLL_FACTOR_RESET && dco_tap == lpm_pkg::DCO_MIN_TAP)
		else $error("reset values wrong");

	a_osc_off_aux: assert property (@(posedge clk) disable iff (reset)
		ctl.crystal_osc_disable |=> !clk_en.aux_clk_on)
		else $error("crystal off left auxiliary clock on");

	a_mode_two_master: assert property (@(posedge clk) disable iff (reset)
		mode == lpm_pkg::low_power_mode_two |=> clk_en.aux_clk_on && !clk_en.master_clk_on && !clk_en.fll_on)
		else $error("mode two enables wrong");

	a_active_runs: assert property (@(posedge clk) disable iff (reset)
		mode == lpm_pkg::active_run_mode |=> clk_en.cpu_run && periph_run == $past(module_en))
		else $error("active mode enables wrong");

	a_tap_frozen: assert property (@(posedge clk) disable iff (reset)
		!clk_en.fll_on |=> $stable(dco_tap))
		else $error("tap moved with loop stopped");

	a_access_acked: assert property (@(posedge clk) disable iff (reset)
		wb_req |=> wb_ack_o)
		else $error("register access not acknowledged");

endmodule // low_power_mode_clock_gating

// ### dv/osc_partner.sv
`timescale 1ns/1ns
// ============================================================
// Oscillator pins as the analog side drives them
module osc_partner (
	// System
	input  wire logic             clk,
	input  wire logic             reset,
	// Enables from the block
	input  wire lpm_pkg::clk_en_t clk_en,
	// Oscillator pins
	output logic                  crystal_tick_pin,
	output logic                  dco_tick_pin
);
	logic [2:0] div;

	// Stopped oscillators stand low, no stray edges
	always_ff @(posedge clk) begin
		div <= reset ? 3'h0 : div + 3'h1;
		crystal_tick_pin <= ~reset & clk_en.aux_clk_on & div[2];
		dco_tick_pin <= ~reset & clk_en.dc_gen_on & ~dco_tick_pin;
	end
endmodule // osc_partner

// ### dv/low_power_mode_clock_gating_tb.sv
`timescale 1ns/1ns
module low_power_mode_clock_gating_tb;
	// ============================================================
	// Signals
	typedef struct packed {
		logic [7:0]       ctl;
		lpm_pkg::clk_en_t en;
		logic [2:0]       mode;
	} row_t;
	logic             clk, reset, cyc, stb, we, irq, ret, ack, xtal, digital_controlled_osc;
	logic [7:0]       adr;
	logic [3:0]       sel, run, save;
	logic [31:0]      dat, rd, dat_o;
	logic [9:0]       tap, tap0;
	lpm_pkg::clk_en_t en;
	int               err_count, n_checks;
	// Control byte, expected enables, expected mode
	row_t rows [7] = '{
		'{8'h00, 5'h1F, 3'h0}, '{8'h20, 5'h17, 3'h0},
		'{8'h10, 5'h0F, 3'h1}, '{8'h50, 5'h0D, 3'h3},
		'{8'h90, 5'h09, 3'h2}, '{8'hD0, 5'h08, 3'h6}, '{8'h30, 5'h00, 3'h7}};

	low_power_mode_clock_gating dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .irq_event(irq), .interrupt_return_instr(ret),
		.crystal_tick_pin(xtal), .dco_tick_pin(digital_controlled_osc), .clk_en(en), .periph_run(run),
		.periph_save(save), .dco_tap(tap));
	osc_partner osc_u (.clk(clk), .reset(reset), .clk_en(en), .crystal_tick_pin(xtal),
		.dco_tick_pin(digital_controlled_osc));

	// ============================================================
	// Tasks
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Entered just after an edge; leaves one idle cycle behind
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 50);
		rd = dat_o;
		if (i >= 50) err_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	// Event pulses held n cycles, then two edges for the enables to land
	task ev(input logic i, input logic r, input int n);
		irq <= i;
		ret <= r;
		repeat (n) @(posedge clk);
		irq <= 1'b0;
		ret <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ============================================================
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Whole run needs well under 2000 cycles
	initial begin
		#800000;
		err_count++;
		test_done;
	end

	// ============================================================
	// Sequence
	initial begin
		{reset, cyc, stb, we, irq, ret} = 6'h20;
		{adr, dat, sel, err_count, n_checks} = '0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("clk_en", 32'h1F, {27'h0, en});
		chk("tap", 32'h0, {22'h0, tap});
		wb(1'b0, lpm_pkg::ADDR_FLL_FACTOR, 32'h0);
		chk("factor", 32'h1F, rd);
		wb(1'b0, lpm_pkg::ADDR_CORE_STATE, 32'h0);
		chk("core", 32'h0, rd);
		foreach (rows[k]) begin
			wb(1'b1, lpm_pkg::ADDR_CORE_STATE, {24'h0, rows[k].ctl});
			repeat (2) @(posedge clk);
			chk("clk_en", {27'h0, rows[k].en}, {27'h0, en});
			wb(1'b0, lpm_pkg::ADDR_MODE_STATUS, 32'h0);
			chk("mode", {29'h0, rows[k].mode}, rd);
		end
		// Mode four still in force here; peripherals keep running
		wb(1'b1, lpm_pkg::ADDR_MODULE_EN, 32'hF);
		chk("run", 32'hF, {28'h0, run});
		wb(1'b1, lpm_pkg::ADDR_CORE_STATE, 32'h0);
		repeat (2) @(posedge clk);
		chk("run", 32'hF, {28'h0, run});
		wb(1'b1, lpm_pkg::ADDR_MODULE_EN, 32'h0);
		wb(1'b1, 8'h24, 32'hA5);
		wb(1'b0, 8'h24, 32'h0);
		chk("periph", 32'hA5, rd);
		wb(1'b1, lpm_pkg::ADDR_LOCAL_SAVE, 32'h5);
		@(posedge clk);
		chk("save", 32'h5, {28'h0, save});
		wb(1'b0, 8'h3C, 32'h0);
		chk("unmapped", 32'h0, rd);
		// Slow oscillator ticks must pull the tap up
		repeat (64) @(posedge clk);
		chk("tap moved", 32'h1, {31'h0, tap != 10'h0});
		wb(1'b1, lpm_pkg::ADDR_CORE_STATE, 32'h50);
		repeat (4) @(posedge clk);
		tap0 = tap;
		repeat (64) @(posedge clk);
		chk("tap frozen", {22'h0, tap0}, {22'h0, tap});
		// Nested wake-ups, then an extra return on an empty stack
		ev(1'b1, 1'b0, 2);
		chk("wake", 32'h1F, {27'h0, en});
		ev(1'b0, 1'b1, 1);
		chk("inner ret", 32'h1F, {27'h0, en});
		ev(1'b0, 1'b1, 1);
		chk("outer ret", 32'h0D, {27'h0, en});
		ev(1'b0, 1'b1, 1);
		chk("empty ret", 32'h0D, {27'h0, en});
		// Wake and return on adjacent edges
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		@(posedge clk);
		chk("adjacent wake", 32'h1F, {27'h0, en});
		@(posedge clk);
		chk("adjacent ret", 32'h0D, {27'h0, en});
		// Second reset in mid-run
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("clk_en", 32'h1F, {27'h0, en});
		chk("tap", 32'h0, {22'h0, tap});
		wb(1'b0, lpm_pkg::ADDR_CORE_STATE, 32'h0);
		chk("core", 32'h0, rd);
		chk("clk_en", 32'h1F, {27'h0, en});
		test_done;
	end
endmodule // low_power_mode_clock_gating_tb
